/* core/boost_cfg_pkg.sv */
// Purpose: Shared constants for the boost output configuration block
// Assumes: Byte-wide register file, 7-bit register address
// Notes:   Offsets are register indices on the serial port
package boost_cfg_pkg;
    localparam logic [6:0] OFS_FUNCTION_CONTROL   = 7'h00;
    localparam logic [6:0] OFS_TARGET_OUT1        = 7'h03;
    localparam logic [6:0] OFS_TARGET_OUT2        = 7'h04;
    localparam logic [6:0] OFS_OV_LIMIT_OUT1      = 7'h05;
    localparam logic [6:0] OFS_OV_LIMIT_OUT2      = 7'h06;
    localparam logic [6:0] OFS_PEAK_LIMIT_OUT1    = 7'h07;
    localparam logic [6:0] OFS_PEAK_LIMIT_OUT2    = 7'h08;
    localparam logic [6:0] OFS_SELECT_COUNT_LO    = 7'h41;
    localparam logic [6:0] OFS_SELECT_COUNT_HI    = 7'h42;
    // Function control field positions
    localparam int         BIT_CONFIGURATION_DONE = 0;
    localparam int         BIT_OUTPUT_ONE_ENABLE  = 1;
    localparam int         BIT_OUTPUT_TWO_ENABLE  = 2;
    localparam int         BIT_SELECT_LOW_COUNT   = 3;
    localparam logic [7:0] FUNC_WRITABLE_MASK     = 8'h0F;
    // Reset values and peak code maximum
    localparam logic [7:0] RST_FUNCTION_CONTROL   = 8'h00;
    localparam logic [7:0] RST_CODE               = 8'h00;
    localparam logic [7:0] PEAK_CODE_MAX          = 8'h80;
    // Gate supply startup time
    localparam int         GATE_SUPPLY_STARTUP_NS = 1000;
    localparam int         CLK_PERIOD_NS          = 10;
    localparam int         GATE_SUPPLY_STARTUP_CYC =
        (GATE_SUPPLY_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* core/phase_gate_ctrl.sv */
// Purpose: Gate drive gating for one output phase
// Assumes: Comparator inputs already synchronised to CLK_SYS
// Notes:   Switching cycle start is a one-cycle pulse
`timescale 1ns/100ps
module phase_gate_ctrl (
    input  wire logic clk,           // System clock
    input  wire logic srst,          // Synchronous reset
    input  wire logic run,           // Output on and supply ready
    input  wire logic cycle_start,   // Start of switching cycle
    input  wire logic pwm_demand,    // Regulator gate request
    input  wire logic overvoltage,   // Output above limit
    input  wire logic peak_reached,  // Coil current at limit (slope-compensated)
    output logic      gate           // Gate drive
);
    logic peak_hold_r;
    logic peak_hold_nxt;
    logic gate_r;
    logic gate_nxt;

    // Peak latch lasts to the next cycle start; start wins so a new cycle begins clean
    always_comb begin
        peak_hold_nxt = peak_hold_r;
        if (cycle_start) begin
            peak_hold_nxt = 1'b0;
        end else if (peak_reached) begin
            peak_hold_nxt = 1'b1;
        end
        gate_nxt = run && pwm_demand && !overvoltage
                   && !peak_hold_nxt && !peak_reached;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            peak_hold_r <= 1'b0;
            gate_r      <= 1'b0;
        end else begin
            peak_hold_r <= peak_hold_nxt;
            gate_r      <= gate_nxt;
        end
    end

    assign gate = gate_r;

    property p_ov_blocks;
        @(posedge clk) disable iff (srst) overvoltage |=> !gate;
    endproperty
    a_ov_blocks: assert property (p_ov_blocks) else $error("gate toggled during overvoltage");

    property p_peak_holds;
        @(posedge clk) disable iff (srst) (peak_reached && !cycle_start) ##1 !cycle_start |=> !gate;
    endproperty
    a_peak_holds: assert property (p_peak_holds) else $error("gate on after peak in same cycle");

    property p_resume;
        @(posedge clk) disable iff (srst)
            (run && pwm_demand && !overvoltage && !peak_reached && cycle_start) |=> gate;
    endproperty
    a_resume: assert property (p_resume) else $error("gate did not resume");

    c_peak_cut: cover property (@(posedge clk) disable iff (srst) gate ##1 !gate && peak_hold_r);
endmodule // phase_gate_ctrl

/* core/boost_output_config_enable.sv */
// Purpose: Register file, mode lock and output enable sequencing for a two-output boost
// Assumes: Serial frame already decoded into byte writes and reads on CLK_SYS
// Notes:   Analog loop, phase timing and trimming live elsewhere
`timescale 1ns/100ps

module boost_output_config_enable #(
    parameter int STARTUP_CYC = boost_cfg_pkg::GATE_SUPPLY_STARTUP_CYC
) (
    input  wire logic       CLK_SYS,            // System clock, 100 MHz
    input  wire logic       SRST,               // Synchronous reset, high
    input  wire logic       REG_WR,             // Register write strobe
    input  wire logic       REG_RD,             // Register read strobe
    input  wire logic [6:0] REG_ADDR,           // Register address
    input  wire logic [7:0] REG_WDATA,          // Write data
    output logic      [7:0] REG_RDATA,          // Read data, registered
    input  wire logic       CHIP_SELECT_PIN_N,  // Serial chip select, low active
    input  wire logic       GATE_SUPPLY_OK,     // Gate supply ready comparator
    input  wire logic [1:0] OVERVOLTAGE,        // Output above limit, per output
    input  wire logic [1:0] PEAK_REACHED,       // Sense comparator at peak, per output
    input  wire logic [1:0] PWM_DEMAND,         // Regulator gate request, per output
    input  wire logic       CYCLE_START,        // Switching cycle start pulse
    output logic      [7:0] TARGET_CODE_1,      // Target code output 1
    output logic      [7:0] TARGET_CODE_2,      // Target code output 2
    output logic      [7:0] OV_LIMIT_CODE_1,    // Overvoltage code output 1
    output logic      [7:0] OV_LIMIT_CODE_2,    // Overvoltage code output 2
    output logic      [7:0] PEAK_CODE_1,        // Peak current code output 1
    output logic      [7:0] PEAK_CODE_2,        // Peak current code output 2
    output logic            GATE_SUPPLY_EN,     // Gate supply regulator on
    output logic            GATE_SUPPLY_READY,  // Ready flag, supply usable
    output logic      [1:0] GATE                // Gate drive per output
);
    logic [7:0]  func_r, func_nxt;
    logic [7:0]  code_r [6];
    logic [7:0]  code_nxt [6];
    logic [7:0]  rdata_r, rdata_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] cnt_run_r, cnt_run_nxt;
    logic [15:0] startup_r, startup_nxt;
    logic [2:0]  cs_sync_r;
    logic [1:0]  ok_sync_r;
    logic [1:0]  ov_s1_r, ov_s2_r, pk_s1_r, pk_s2_r;
    logic        locked, cs_low, cs_rise, supply_ready;
    logic        func_was_on_r, func_was_on_nxt;
    logic [1:0]  out_on, run;

    // Index of a code register, or 7 when not one
    function automatic logic [2:0] code_index(input logic [6:0] a);
        if (a >= boost_cfg_pkg::OFS_TARGET_OUT1 && a <= boost_cfg_pkg::OFS_PEAK_LIMIT_OUT2) begin
            code_index = 3'(a - boost_cfg_pkg::OFS_TARGET_OUT1);
        end else begin
            code_index = 3'h7;
        end
    endfunction

    assign locked  = func_r[boost_cfg_pkg::BIT_CONFIGURATION_DONE];
    assign cs_low  = !cs_sync_r[1];
    assign cs_rise = cs_sync_r[1] && !cs_sync_r[2];

    // Output on needs mode, enable bit and nonzero target and limit codes
    assign out_on[0] = locked && func_r[boost_cfg_pkg::BIT_OUTPUT_ONE_ENABLE]
                       && (code_r[0] != 8'h00) && (code_r[2] != 8'h00);
    assign out_on[1] = locked && func_r[boost_cfg_pkg::BIT_OUTPUT_TWO_ENABLE]
                       && (code_r[1] != 8'h00) && (code_r[3] != 8'h00);
    assign supply_ready = ok_sync_r[1] && (startup_r == 16'(STARTUP_CYC));
    // Zero peak code allows no coil current, so the gate never fires
    assign run[0] = out_on[0] && supply_ready && (code_r[4] != 8'h00);
    assign run[1] = out_on[1] && supply_ready && (code_r[5] != 8'h00);

    // Register writes and reads
    always_comb begin
        func_nxt  = func_r;
        rdata_nxt = rdata_r;
        for (int i = 0; i < 6; i++) begin
            code_nxt[i] = code_r[i];
        end
        if (REG_WR && REG_ADDR == boost_cfg_pkg::OFS_FUNCTION_CONTROL) begin
            // Reserved bits kept clear whatever the host sends
            func_nxt = REG_WDATA & boost_cfg_pkg::FUNC_WRITABLE_MASK;
        end else if (REG_WR && code_index(REG_ADDR) != 3'h7 && !locked) begin
            code_nxt[code_index(REG_ADDR)] = REG_WDATA;
        end
        if (REG_RD) begin
            if (REG_ADDR == boost_cfg_pkg::OFS_FUNCTION_CONTROL) begin
                rdata_nxt = func_r;
            end else if (code_index(REG_ADDR) != 3'h7) begin
                rdata_nxt = code_r[code_index(REG_ADDR)];
            end else if (REG_ADDR == boost_cfg_pkg::OFS_SELECT_COUNT_LO) begin
                rdata_nxt = cnt_r[7:0];
            end else if (REG_ADDR == boost_cfg_pkg::OFS_SELECT_COUNT_HI) begin
                rdata_nxt = cnt_r[15:8];
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Chip-select low counter; result published at frame end while enabled
    always_comb begin
        cnt_run_nxt = cnt_run_r;
        cnt_nxt     = cnt_r;
        if (cs_low) begin
            if (cnt_run_r != 16'hFFFF) begin
                cnt_run_nxt = cnt_run_r + 16'h0001;
            end
        end else begin
            cnt_run_nxt = 16'h0000;
        end
        // Enable now or at the last frame end, so the clearing frame still publishes
        if (cs_rise && (func_r[boost_cfg_pkg::BIT_SELECT_LOW_COUNT] || func_was_on_r)) begin
            cnt_nxt = cnt_run_r;
        end
    end

    // Enable seen at the last frame end, lets the clearing frame publish once
    always_comb begin
        func_was_on_nxt = func_was_on_r;
        if (cs_rise) begin
            func_was_on_nxt = func_r[boost_cfg_pkg::BIT_SELECT_LOW_COUNT];
        end
    end

    // Startup timer runs while the supply regulator is on
    always_comb begin
        startup_nxt = 16'h0000;
        if (out_on != 2'b00) begin
            startup_nxt = (startup_r == 16'(STARTUP_CYC)) ? startup_r : startup_r + 16'h0001;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            func_r        <= boost_cfg_pkg::RST_FUNCTION_CONTROL;
            rdata_r       <= 8'h00;
            cnt_r         <= 16'h0000;
            cnt_run_r     <= 16'h0000;
            startup_r     <= 16'h0000;
            func_was_on_r <= 1'b0;
            cs_sync_r     <= 3'b111;
            ok_sync_r     <= 2'b00;
            ov_s1_r       <= 2'b00;
            ov_s2_r       <= 2'b00;
            pk_s1_r       <= 2'b00;
            pk_s2_r       <= 2'b00;
            for (int i = 0; i < 6; i++) begin
                code_r[i] <= boost_cfg_pkg::RST_CODE;
            end
        end else begin
            func_r        <= func_nxt;
            rdata_r       <= rdata_nxt;
            cnt_r         <= cnt_nxt;
            cnt_run_r     <= cnt_run_nxt;
            startup_r     <= startup_nxt;
            func_was_on_r <= func_was_on_nxt;
            cs_sync_r     <= {cs_sync_r[1:0], CHIP_SELECT_PIN_N};
            ok_sync_r     <= {ok_sync_r[0], GATE_SUPPLY_OK};
            ov_s1_r       <= OVERVOLTAGE;
            ov_s2_r       <= ov_s1_r;
            pk_s1_r       <= PEAK_REACHED;
            pk_s2_r       <= pk_s1_r;
            for (int i = 0; i < 6; i++) begin
                code_r[i] <= code_nxt[i];
            end
        end
    end

    // One gate controller per output
    for (genvar g = 0; g < 2; g++) begin : g_phase
        phase_gate_ctrl u_gate (
            .clk          (CLK_SYS),
            .srst         (SRST),
            .run          (run[g]),
            .cycle_start  (CYCLE_START),
            .pwm_demand   (PWM_DEMAND[g]),
            .overvoltage  (ov_s2_r[g]),
            .peak_reached (pk_s2_r[g]),
            .gate         (GATE[g])
        );
    end

    assign REG_RDATA         = rdata_r;
    assign TARGET_CODE_1     = code_r[0];
    assign TARGET_CODE_2     = code_r[1];
    assign OV_LIMIT_CODE_1   = code_r[2];
    assign OV_LIMIT_CODE_2   = code_r[3];
    assign PEAK_CODE_1       = code_r[4];
    assign PEAK_CODE_2       = code_r[5];
    assign GATE_SUPPLY_EN    = out_on != 2'b00;
    assign GATE_SUPPLY_READY = supply_ready;

    property p_lock_write;
        @(posedge CLK_SYS) disable iff (SRST)
            (REG_WR && locked && REG_ADDR == boost_cfg_pkg::OFS_TARGET_OUT1) |=> $stable(code_r[0]);
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("locked target changed");

    property p_enable_mode;
        @(posedge CLK_SYS) disable iff (SRST) !locked |-> GATE_SUPPLY_EN == 1'b0;
    endproperty
    a_enable_mode: assert property (p_enable_mode) else $error("supply on in config mode");

    // Checked against the register contents, not the internal on flags
    property p_supply_on;
        @(posedge CLK_SYS) disable iff (SRST)
            (locked && func_r[boost_cfg_pkg::BIT_OUTPUT_ONE_ENABLE] && code_r[0] != 8'h00 && code_r[2] != 8'h00)
            |-> GATE_SUPPLY_EN;
    endproperty
    a_supply_on: assert property (p_supply_on) else $error("supply off with output on");

    property p_no_gate_early;
        @(posedge CLK_SYS) disable iff (SRST) !supply_ready |=> GATE == 2'b00;
    endproperty
    a_no_gate_early: assert property (p_no_gate_early) else $error("gate before supply ready");

    property p_zero_target;
        @(posedge CLK_SYS) disable iff (SRST) code_r[0] == 8'h00 |-> !out_on[0];
    endproperty
    a_zero_target: assert property (p_zero_target) else $error("output on with zero target");

    property p_zero_limit;
        @(posedge CLK_SYS) disable iff (SRST) code_r[3] == 8'h00 |-> !out_on[1];
    endproperty
    a_zero_limit: assert property (p_zero_limit) else $error("output on with zero limit");

    property p_zero_peak;
        @(posedge CLK_SYS) disable iff (SRST) code_r[4] == 8'h00 |=> !GATE[0];
    endproperty
    a_zero_peak: assert property (p_zero_peak) else $error("gate with zero peak code");

    property p_count_frozen;
        @(posedge CLK_SYS) disable iff (SRST)
            (!func_r[boost_cfg_pkg::BIT_SELECT_LOW_COUNT] && !func_was_on_r) |=> $stable(cnt_r);
    endproperty
    a_count_frozen: assert property (p_count_frozen) else $error("count moved while frozen");

    property p_reserved;
        @(posedge CLK_SYS) disable iff (SRST) func_r[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    c_lock: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(locked));
    c_ready: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(supply_ready));
    c_gate: cover property (@(posedge CLK_SYS) disable iff (SRST) GATE[1]);
endmodule // boost_output_config_enable

/* sim/boost_plant_model.sv */
// Purpose: Power stage stand-in for the boost configuration block
// Assumes: One clock; supply comparator settles a few cycles after enable
// Notes:   Demand held high so gate state shows the gating logic alone
`timescale 1ns/100ps
module boost_plant_model (
    input  wire logic       clk,         // System clock
    input  wire logic       supply_en,   // Gate supply regulator on
    output logic            supply_ok,   // Gate supply good
    output logic            cycle_start, // Switching cycle pulse
    output logic      [1:0] pwm_demand   // Regulator gate request
);
    logic [4:0] phase_r = 5'h00;
    logic [1:0] ramp_r  = 2'h0;

    // Supply ramps up slowly, collapses at once when disabled
    always_ff @(posedge clk) begin
        ramp_r  <= supply_en ? ((ramp_r == 2'h3) ? ramp_r : ramp_r + 2'h1) : 2'h0;
        phase_r <= phase_r + 5'h01;
    end

    // One switching cycle every 32 clocks
    assign supply_ok   = (ramp_r == 2'h3);
    assign cycle_start = (phase_r == 5'h00);
    assign pwm_demand  = 2'b11;
endmodule // boost_plant_model

/* sim/tb_boost_output_config_enable.sv */
// Purpose: Self-checking bench for the boost configuration block
// Assumes: Short supply startup count of 4 cycles
// Notes:   Select count checked as exact clock cycles of chip select low
`timescale 1ns/100ps
module tb_boost_output_config_enable;
    logic       clk_sys = 1'b0;
    logic       srst    = 1'b1;
    logic       reg_wr  = 1'b0;
    logic       reg_rd  = 1'b0;
    logic [6:0] reg_addr  = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       cs_n    = 1'b1;
    logic [1:0] ov      = 2'b00;
    logic [1:0] peak    = 2'b00;
    logic       sup_ok, cyc, sup_en, sup_rdy;
    logic [1:0] dem, gate;
    logic [7:0] tgt1, tgt2, ovl1, ovl2, pk1, pk2, v, c1, c2;
    int         fail_count = 0;
    int         samples_checked = 0;

    // Clock at 100 MHz
    always #5 clk_sys = ~clk_sys;

    boost_output_config_enable #(.STARTUP_CYC(4)) dut (
        .CLK_SYS(clk_sys), .SRST(srst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CHIP_SELECT_PIN_N(cs_n),
        .GATE_SUPPLY_OK(sup_ok), .OVERVOLTAGE(ov), .PEAK_REACHED(peak), .PWM_DEMAND(dem),
        .CYCLE_START(cyc), .TARGET_CODE_1(tgt1), .TARGET_CODE_2(tgt2), .OV_LIMIT_CODE_1(ovl1),
        .OV_LIMIT_CODE_2(ovl2), .PEAK_CODE_1(pk1), .PEAK_CODE_2(pk2), .GATE_SUPPLY_EN(sup_en),
        .GATE_SUPPLY_READY(sup_rdy), .GATE(gate));

    boost_plant_model plant (.clk(clk_sys), .supply_en(sup_en), .supply_ok(sup_ok),
        .cycle_start(cyc), .pwm_demand(dem));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle strobes launched at the falling edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_rd = 1'b1; reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Frame of n clocks with chip select low
    task automatic frame(input int n);
        @(negedge clk_sys);
        cs_n = 1'b0;
        cyc_wait(n);
        cs_n = 1'b1;
        cyc_wait(4);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog sized well beyond the sequence length
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        results;
    end

    initial begin
        // Reset seen on four rising edges
        cyc_wait(4);
        srst = 1'b0;
        // Reset values, code registers and unmapped address
        for (int a = 0; a < 9; a++) begin
            rd(a[6:0], v);
            check(v, 8'h00);
        end
        // Code registers hold what was written, unmapped ignores
        for (int a = 3; a < 9; a++) wr(a[6:0], 8'h10 + a[7:0]);
        for (int a = 3; a < 9; a++) begin
            rd(a[6:0], v);
            check(v, 8'h10 + a[7:0]);
        end
        check(tgt1, 8'h13);
        check(tgt2, 8'h14);
        check(ovl1, 8'h15);
        check(ovl2, 8'h16);
        check(pk1, 8'h17);
        check(pk2, 8'h18);
        wr(7'h01, 8'hAA);
        rd(7'h01, v);
        check(v, 8'h00);
        wr(7'h00, 8'hF8);
        rd(7'h00, v);
        check(v, 8'h08);
        wr(7'h00, 8'h02);
        cyc_wait(3);
        check({7'h0, sup_en}, 8'h00);
        $display("test registers done");

        // Host keeps limit above target and peak below 0x80
        wr(7'h03, 8'h40); wr(7'h05, 8'h50);
        wr(7'h07, 8'h60); wr(7'h08, 8'h60);
        wr(7'h00, 8'h03);
        @(negedge clk_sys);
        check({7'h0, sup_en}, 8'h01);
        check({7'h0, sup_rdy}, 8'h00);
        cyc_wait(12);
        check({7'h0, sup_rdy}, 8'h01);
        check({6'h0, gate}, 8'h01);
        wr(7'h03, 8'h11);
        rd(7'h03, v);
        check(v, 8'h40);
        check(tgt1, 8'h40);
        $display("test enable done");

        // Overvoltage turns the gate off, gate back on once cleared
        @(negedge clk_sys);
        ov = 2'b01;
        cyc_wait(4);
        check({6'h0, gate}, 8'h00);
        ov = 2'b00;
        cyc_wait(4);
        check({6'h0, gate}, 8'h01);
        $display("test overvoltage done");

        // Peak event keeps gate off until next switching cycle
        @(posedge cyc);
        @(negedge clk_sys);
        peak = 2'b01;
        cyc_wait(2);
        peak = 2'b00;
        cyc_wait(8);
        check({6'h0, gate}, 8'h00);
        @(posedge cyc);
        cyc_wait(3);
        check({6'h0, gate}, 8'h01);
        $display("test peak done");

        // Zero codes keep outputs off
        wr(7'h00, 8'h00); wr(7'h07, 8'h00); wr(7'h00, 8'h03);
        cyc_wait(12);
        check({6'h0, gate}, 8'h00);
        wr(7'h00, 8'h00); wr(7'h04, 8'h00); wr(7'h06, 8'h50); wr(7'h00, 8'h05);
        cyc_wait(2);
        check({7'h0, sup_en}, 8'h00);
        wr(7'h00, 8'h00); wr(7'h04, 8'h40); wr(7'h06, 8'h00); wr(7'h00, 8'h05);
        cyc_wait(2);
        check({7'h0, sup_en}, 8'h00);
        wr(7'h00, 8'h00); wr(7'h06, 8'h50); wr(7'h00, 8'h05);
        cyc_wait(12);
        check({6'h0, gate}, 8'h02);
        $display("test zero codes done");

        // Select count publishes, then freezes after clearing frame
        wr(7'h00, 8'h08);
        frame(20);
        rd(7'h41, c1);
        check(c1, 8'h14);
        @(negedge clk_sys);
        cs_n = 1'b0;
        wr(7'h00, 8'h00);
        cyc_wait(30);
        cs_n = 1'b1;
        cyc_wait(4);
        rd(7'h41, c2);
        check(c2, 8'h20);
        frame(50);
        rd(7'h41, v);
        check(v, c2);
        rd(7'h42, v);
        check(v, 8'h00);
        $display("test select count done");
        results;
    end
endmodule // tb_boost_output_config_enable
